// *** src/lcd_fmt_consts.svh ***
// Register offsets, field positions, reset values and last palette word indices of the pixel formatter.
`ifndef LCD_FMT_CONSTS_SVH
`define LCD_FMT_CONSTS_SVH
`define OFF_CTRL 12'h000
`define OFF_SPECIAL 12'h004
`define OFF_TIMING 12'h008
`define OFF_POS_BASE 12'h00C
`define OFF_PALCTL 12'h01C
`define OFF_STATUS 12'h020
`define CTRL_RST 32'h0000_0000
`define SPECIAL_RST 32'h0000_0000
`define TIMING_RST 32'h0007_001F
`define POS_RST 32'h0002_0001
`define F_EN 0
`define F_MODE_LO 1
`define F_WIDTH_LO 4
`define F_BPP_LO 6
`define F_CFMT 9
`define F_VPOL 10
`define F_HPOL 11
`define F_CPOL 12
`define F_DUAL 13
`define F_SMODE_LO 0
`define F_SPOL_LO 2
`define F_ODD_LO 6
`define F_EVEN_LO 8
`define F_LO_LO 0
`define F_HI_LO 16
`define PAL_WORDS_8BPP 7'h7F
`define PAL_WORDS_4BPP 7'h07
`define PAL_WORDS_2BPP 7'h01
`define PAL_WORDS_1BPP 7'h00
`define PAL_DMA_CHANNEL 2'h0
`endif

// *** src/lcd_fmt_pkg.sv ***
// Types shared by the pixel output formatter and its bench.
package lcd_fmt_pkg;
   typedef enum logic [2:0] {
      MONO_STN, COLOUR_STN, TFT_PARALLEL, TFT_SERIAL, TFT_DELTA, TFT_DUMMY
   } panel_mode_t;
   typedef enum logic [2:0] {BPP1, BPP2, BPP4, EIGHT_BITS_PER_PIXEL, BPP16} bpp_t;
   typedef struct packed {
      logic [4:0] r;
      logic [5:0] g;
      logic [4:0] b;
   } rgb_t;
   // Index order of the four special timing signals.
   typedef enum logic [1:0] {SIG_CLS, SIG_REV, SIG_SPL, SIG_PWR} special_sig_t;
   typedef struct packed {
      logic pclk;
      logic vsync;
      logic hsync;
      logic pixel_valid_pin;
      logic line_clear;
      logic reverse;
      logic start_pulse;
      logic power_save_signal;
      logic [17:0] data;
   } panel_pins_t;
endpackage

// *** src/lcd_pixel_output_formatter.sv ***
// Pixel output formatter: panel pin mapping, special TFT signals and palette.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "lcd_fmt_consts.svh"
module lcd_pixel_output_formatter (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pixel clock from the clock generator, asynchronous to pclk.
   input wire logic link_clk,
   // Pixel stream; in dual panel mode the upper half is the lower panel.
   input wire logic pix_valid,
   input wire logic [31:0] pix_data,
   output logic pix_ready,
   // Palette DMA.
   output logic pal_dma_req,
   output logic [1:0] pal_dma_chan,
   output logic [6:0] pal_dma_word,
   input wire logic pal_dma_valid,
   input wire logic [31:0] pal_dma_data,
   // Panel pins.
   output lcd_fmt_pkg::panel_pins_t pins
);
   import lcd_fmt_pkg::*;

   logic [31:0] ctrl_q, special_q, timing_q;
   logic [31:0] pos_q [4];
   logic [15:0] pal_mem [256];
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic lk1_q, lk2_q, lk3_q;
   logic tick;
   logic en_q, was_en_q, null_q;
   logic [11:0] h_q, v_q;
   logic [1:0] comp_q;
   logic [31:0] held_q;
   logic [7:0] up_sh_q, lo_sh_q;
   logic [2:0] cnt_q;
   logic bias_q;
   logic [3:0] tog_q;
   logic pal_busy_q;
   logic [6:0] pal_word_q;
   panel_pins_t pins_q;

   // Decoded control fields.
   panel_mode_t mode;
   bpp_t bpp;
   logic [1:0] panel_data_width, smode;
   logic [3:0] spol;
   logic dual, passive_matrix_panel, active, take, line_end, frame_end;
   logic [11:0] line_last, frame_last;
   logic [1:0] ncomp_last;
   logic [31:0] cur;
   rgb_t up_rgb, lo_rgb;
   logic [3:0] tmode, pulse_act;

   assign mode = panel_mode_t'(ctrl_q[`F_MODE_LO +: 3]);
   assign panel_data_width = ctrl_q[`F_WIDTH_LO +: 2];
   assign bpp = bpp_t'(ctrl_q[`F_BPP_LO +: 3]);
   assign dual = ctrl_q[`F_DUAL];
   assign smode = special_q[`F_SMODE_LO +: 2];
   assign spol = special_q[`F_SPOL_LO +: 4];
   assign line_last = timing_q[`F_LO_LO +: 12];
   assign frame_last = timing_q[`F_HI_LO +: 12];
   assign passive_matrix_panel = (mode == MONO_STN) || (mode == COLOUR_STN);

   // Palette index for the low bpp modes; unused index bits are masked off.
   function automatic logic [7:0] pal_index(input bpp_t b, input logic [7:0] p);
      case (b)
         BPP1: pal_index = {7'h00, p[0]};
         BPP2: pal_index = {6'h00, p[1:0]};
         BPP4: pal_index = {4'h0, p[3:0]};
         default: pal_index = p;
      endcase
   endfunction

   // 16-bit colour decode; 555 drops bit 15 and widens green by its msb.
   function automatic rgb_t decode(input logic [15:0] w, input logic fmt555);
      rgb_t c;
      c = w;
      if (fmt555)
      begin
         c.r = w[14:10];
         c.g = {w[9:5], w[9]};
         c.b = w[4:0];
      end
      return c;
   endfunction

   // One 8-bit colour component; select 3 is the dummy slot.
   function automatic logic [7:0] component(input rgb_t c, input logic [1:0] sel);
      case (sel)
         2'h0: component = {c.r, 3'h0};
         2'h1: component = {c.g, 2'h0};
         2'h2: component = {c.b, 3'h0};
         default: component = 8'h00;
      endcase
   endfunction

   // Palette lookup or bypass, then colour decode.
   function automatic rgb_t pixel_colour(input logic [15:0] p);
      logic [15:0] w;
      w = p;
      if (bpp != BPP16)
         w = pal_mem[pal_index(bpp, p[7:0])];
      return decode(w, ctrl_q[`F_CFMT]);
   endfunction

   // APB: zero wait states; read data is latched in the setup cycle.
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr_q <= 1'b0;
         case (paddr)
            `OFF_CTRL: prdata_q <= ctrl_q;
            `OFF_SPECIAL: prdata_q <= special_q;
            `OFF_TIMING: prdata_q <= timing_q;
            `OFF_POS_BASE: prdata_q <= pos_q[0];
            `OFF_POS_BASE + 12'h004: prdata_q <= pos_q[1];
            `OFF_POS_BASE + 12'h008: prdata_q <= pos_q[2];
            `OFF_POS_BASE + 12'h00C: prdata_q <= pos_q[3];
            `OFF_PALCTL: prdata_q <= {31'h0000_0000, pal_busy_q};
            `OFF_STATUS: prdata_q <= {4'h0, v_q, 8'h00, pal_word_q, null_q};
            default:
            begin
               prdata_q <= 32'h0000_0000;
               pslverr_q <= 1'b1;
            end
         endcase
      end
   end

   // Register writes take effect in the access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= `CTRL_RST;
         special_q <= `SPECIAL_RST;
         timing_q <= `TIMING_RST;
         for (int i = 0; i < 4; i++)
            pos_q[i] <= `POS_RST;
      end
      else if (psel && penable && pwrite)
      begin
         case (paddr)
            `OFF_CTRL: ctrl_q <= {18'h0_0000, pwdata[13:0]};
            `OFF_SPECIAL: special_q <= {22'h00_0000, pwdata[9:0]};
            `OFF_TIMING: timing_q <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
            `OFF_POS_BASE: pos_q[0] <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
            `OFF_POS_BASE + 12'h004: pos_q[1] <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
            `OFF_POS_BASE + 12'h008: pos_q[2] <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
            `OFF_POS_BASE + 12'h00C: pos_q[3] <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
            default: ;
         endcase
      end
   end

   // Pixel clock synchroniser; the third stage only feeds edge detection.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lk1_q <= 1'b0;
         lk2_q <= 1'b0;
         lk3_q <= 1'b0;
      end
      else
      begin
         lk1_q <= link_clk;
         lk2_q <= lk1_q;
         lk3_q <= lk2_q;
      end
   end
   assign tick = lk2_q && !lk3_q;

   // Palette load: each word writes an even and the next odd entry.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pal_busy_q <= 1'b0;
         pal_word_q <= 7'h00;
      end
      else if (!pal_busy_q)
      begin
         if (psel && penable && pwrite && paddr == `OFF_PALCTL && pwdata[0]
             && bpp != BPP16)
         begin
            pal_busy_q <= 1'b1;
            pal_word_q <= 7'h00;
         end
      end
      else if (pal_dma_valid)
      begin
         pal_word_q <= pal_word_q + 7'h01;
         case (bpp)
            BPP1: pal_busy_q <= pal_word_q != `PAL_WORDS_1BPP;
            BPP2: pal_busy_q <= pal_word_q != `PAL_WORDS_2BPP;
            BPP4: pal_busy_q <= pal_word_q != `PAL_WORDS_4BPP;
            default: pal_busy_q <= pal_word_q != `PAL_WORDS_8BPP;
         endcase
      end
   end

   // Palette storage has no reset; software loads it before use.
   always_ff @(posedge pclk)
   begin
      if (pal_busy_q && pal_dma_valid)
      begin
         pal_mem[{pal_word_q, 1'b0}] <= pal_dma_data[15:0];
         pal_mem[{pal_word_q, 1'b1}] <= pal_dma_data[31:16];
      end
   end

   assign pal_dma_chan = `PAL_DMA_CHANNEL;
   assign pal_dma_req = pal_busy_q;
   assign pal_dma_word = pal_word_q;

   // Raster position; a disable parks the counters at the frame origin.
   assign line_end = h_q == line_last;
   assign frame_end = line_end && (v_q == frame_last);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_q <= 1'b0;
         was_en_q <= 1'b0;
         null_q <= 1'b1;
         h_q <= 12'h000;
         v_q <= 12'h000;
         bias_q <= 1'b0;
      end
      else
      begin
         en_q <= ctrl_q[`F_EN];
         was_en_q <= en_q;
         if (!en_q)
         begin
            null_q <= 1'b1;
            h_q <= 12'h000;
            v_q <= 12'h000;
         end
         else if (tick)
         begin
            h_q <= line_end ? 12'h000 : h_q + 12'h001;
            if (line_end)
               null_q <= 1'b0;
            if (line_end && !null_q)
               v_q <= frame_end ? 12'h000 : v_q + 12'h001;
            if (frame_end && !null_q)
               bias_q <= !bias_q;
         end
      end
   end

   // Data flows only on display pixels after the null line.
   assign active = en_q && !null_q && v_q != 12'h000 && h_q != 12'h000;
   always_comb
   begin
      case (mode)
         TFT_DUMMY: ncomp_last = 2'h3;
         COLOUR_STN, TFT_SERIAL, TFT_DELTA: ncomp_last = 2'h2;
         default: ncomp_last = 2'h0;
      endcase
   end
   assign take = tick && active && comp_q == 2'h0;
   assign pix_ready = take;
   // An underrun feeds a zero pixel (black at 16 bpp, palette entry 0 otherwise) rather than stale colour.
   assign cur = (comp_q == 2'h0) ? (pix_valid ? pix_data : 32'h0000_0000) : held_q;
   // A process rather than an assign, so palette and format changes re-evaluate the colours.
   always_comb
   begin
      up_rgb = pixel_colour(cur[15:0]);
      lo_rgb = pixel_colour(cur[31:16]);
   end

   // Component sequencing for serial, delta, dummy and colour PASSIVE_MATRIX_PANEL.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         comp_q <= 2'h0;
         held_q <= 32'h0000_0000;
      end
      else if (!active)
         comp_q <= 2'h0;
      else if (tick)
      begin
         comp_q <= (comp_q == ncomp_last) ? 2'h0 : comp_q + 2'h1;
         if (comp_q == 2'h0)
            held_q <= cur;
      end
   end

   // PASSIVE_MATRIX_PANEL shifters: the first pixel of a group ends up in the highest bit.
   logic [2:0] group_last;
   logic up_bit, lo_bit;
   logic [7:0] up_next, lo_next, grp_mask, up_comp, lo_comp;
   always_comb
   begin
      group_last = 3'h7;
      if (mode == MONO_STN)
      begin
         case (panel_data_width)
            2'h0: group_last = 3'h0;
            2'h1: group_last = 3'h1;
            2'h2: group_last = 3'h3;
            default: group_last = 3'h7;
         endcase
      end
      grp_mask = 8'hFF >> (3'h7 - group_last);
      up_comp = component(up_rgb, comp_q);
      lo_comp = component(lo_rgb, comp_q);
      up_bit = (mode == MONO_STN) ? up_rgb.g[5] : up_comp[7];
      lo_bit = (mode == MONO_STN) ? lo_rgb.g[5] : lo_comp[7];
      up_next = {up_sh_q[6:0], up_bit};
      lo_next = {lo_sh_q[6:0], lo_bit};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         up_sh_q <= 8'h00;
         lo_sh_q <= 8'h00;
         cnt_q <= 3'h0;
      end
      else if (!active || !passive_matrix_panel)
         cnt_q <= 3'h0;
      else if (tick)
      begin
         up_sh_q <= up_next;
         lo_sh_q <= lo_next;
         cnt_q <= (cnt_q == group_last) ? 3'h0 : cnt_q + 3'h1;
      end
   end

   // Special signal modes and pulse windows.
   always_comb
   begin
      tmode[SIG_CLS] = 1'b0;
      tmode[SIG_REV] = 1'b1;
      tmode[SIG_SPL] = smode == 2'h3;
      tmode[SIG_PWR] = smode >= 2'h2;
      for (int i = 0; i < 4; i++)
         pulse_act[i] = h_q >= pos_q[i][11:0] && h_q < pos_q[i][27:16] && !null_q;
   end

   // Toggle states; the null line keeps them at their start level.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tog_q <= 4'h0;
      else if (en_q && !was_en_q)
      begin
         tog_q <= 4'h0;
         tog_q[SIG_SPL] <= smode == 2'h3;
      end
      else if (tick && en_q && !null_q)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (i != SIG_SPL && h_q == pos_q[i][11:0])
               tog_q[i] <= !tog_q[i];
         end
         // no start-pulse toggle at the end of a frame with an odd line count
         if (line_end && !(frame_end && !frame_last[0]))
            tog_q[SIG_SPL] <= !tog_q[SIG_SPL];
      end
   end

   // Pin mapping, all registered.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pins_q <= '0;
      else
      begin
         pins_q.pclk <= lk2_q ^ ctrl_q[`F_CPOL];
         pins_q.vsync <= (en_q && v_q == 12'h000) ^ ctrl_q[`F_VPOL];
         pins_q.hsync <= (en_q && h_q == 12'h000) ^ ctrl_q[`F_HPOL];
         pins_q.pixel_valid_pin <= passive_matrix_panel ? bias_q : active;
         pins_q.line_clear <= spol[SIG_CLS];
         pins_q.reverse <= spol[SIG_REV];
         pins_q.start_pulse <= spol[SIG_SPL];
         pins_q.power_save_signal <= spol[SIG_PWR];
         if (!passive_matrix_panel && smode != 2'h0 && en_q)
         begin
            pins_q.line_clear <= pulse_act[SIG_CLS] ^ spol[SIG_CLS];
            pins_q.reverse <= tog_q[SIG_REV] ^ spol[SIG_REV];
            pins_q.start_pulse <= (tmode[SIG_SPL] ? tog_q[SIG_SPL] : pulse_act[SIG_SPL])
                                  ^ spol[SIG_SPL];
            pins_q.power_save_signal <= (tmode[SIG_PWR] ? tog_q[SIG_PWR] : pulse_act[SIG_PWR])
                                        ^ spol[SIG_PWR];
         end
         if (!active)
            pins_q.data <= 18'h0_0000;
         else if (tick)
         begin
            case (mode)
               MONO_STN, COLOUR_STN:
               begin
                  if (cnt_q == group_last)
                  begin
                     pins_q.data <= 18'h0_0000;
                     if (!dual)
                        pins_q.data[7:0] <= up_next & grp_mask;
                     else if (panel_data_width == 2'h3)
                        pins_q.data[15:0] <= {up_next, lo_next};
                     else if (panel_data_width == 2'h2)
                        pins_q.data[11:0] <= {up_next[3:0], 4'h0, lo_next[3:0]};
                  end
               end
               TFT_PARALLEL:
               begin
                  if (panel_data_width == 2'h3)
                     pins_q.data <= {up_rgb.r, up_rgb.r[4], up_rgb.g, up_rgb.b, up_rgb.b[4]};
                  else
                     pins_q.data <= {2'h0, up_rgb};
               end
               TFT_DELTA:
               begin
                  if (v_q[0])
                     pins_q.data <= {10'h000, component(up_rgb, 2'((comp_q
                        + special_q[`F_ODD_LO +: 2]) % 3))};
                  else
                     pins_q.data <= {10'h000, component(up_rgb, 2'((comp_q
                        + special_q[`F_EVEN_LO +: 2]) % 3))};
               end
               default: pins_q.data <= {10'h000, component(up_rgb, comp_q)};
            endcase
         end
      end
   end
   assign pins = pins_q;

endmodule // lcd_pixel_output_formatter

// *** tb/lcd_fmt_monitor.sv ***
// Port checker of the pixel output formatter.
`timescale 1ns/100ps
`include "lcd_fmt_consts.svh"
module lcd_fmt_monitor (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Register bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Stream, palette and panel.
   input wire logic pix_ready,
   input wire logic pal_dma_req,
   input wire logic [1:0] pal_dma_chan,
   input wire logic [6:0] pal_dma_word,
   input wire logic pal_dma_valid,
   input wire lcd_fmt_pkg::panel_pins_t pins
);
   import lcd_fmt_pkg::*;
   logic [31:0] ctrl_q;
   logic [5:0] spec_q;
   logic [1:0] age_q;
   logic [17:0] mask;
   logic [6:0] last;
   logic wr;
   assign wr = psel && penable && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow copies; age lets the pins settle after a configuration change.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= 32'h0000_0000;
         spec_q <= 6'h00;
         age_q <= 2'h0;
      end
      else
      begin
         if (wr && paddr == `OFF_CTRL)
            ctrl_q <= pwdata;
         if (wr && paddr == `OFF_SPECIAL)
            spec_q <= pwdata[5:0];
         age_q <= (wr && paddr < `OFF_TIMING) ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
      end
   end
   // Pins in use for the width code, and the last palette word for the depth.
   always_comb
   begin
      if (ctrl_q[13])
         mask = ctrl_q[5:4] == 2'h3 ? 18'h0_FFFF : (ctrl_q[5:4] == 2'h2 ? 18'h0_0F0F : 18'h0);
      else
         mask = 18'h0_00FF >> (8 - (1 << ctrl_q[5:4]));
      last = ctrl_q[8:6] == 3'h3 ? 7'h7F : (ctrl_q[8:6] == 3'h2 ? 7'h07 : {6'h0, ctrl_q[6]});
   end
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("bus access not answered at once");
   a_unmapped_err: assert property (psel && penable && paddr > `OFF_STATUS |-> pslverr)
      else $error("unmapped access not flagged");
   a_dma_chan: assert property (pal_dma_chan == 2'h0)
      else $error("palette channel is not zero");
   a_word_step: assert property (pal_dma_req && pal_dma_valid |=>
      !pal_dma_req || pal_dma_word == $past(pal_dma_word) + 7'h01)
      else $error("palette word index did not step");
   a_load_start: assert property (wr && paddr == `OFF_PALCTL && pwdata[0]
      && !pal_dma_req && ctrl_q[8:6] < 3'h4 |=> pal_dma_req && pal_dma_word == 7'h00)
      else $error("palette load did not start at word zero");
   a_load_end: assert property (pal_dma_req && pal_dma_valid && pal_dma_word == last
      |=> !pal_dma_req)
      else $error("palette load ran past its last word");
   a_bypass_idle: assert property (wr && paddr == `OFF_PALCTL && ctrl_q[8:6] == 3'h4
      && !pal_dma_req |=> !pal_dma_req [*4])
      else $error("palette load started at sixteen bits per pixel");
   a_special_idle: assert property (age_q == 2'h3 && (ctrl_q[3:1] < 3'h2
      || spec_q[1:0] == 2'h0) |-> {pins.power_save_signal, pins.start_pulse,
      pins.reverse, pins.line_clear} == spec_q[5:2])
      else $error("special output not at its inactive level");
   a_mono_pins: assert property (age_q == 2'h3 && ctrl_q[3:1] == 3'h0
      |-> (pins.data & ~mask) == 18'h0_0000)
      else $error("unused data pin driven");
   a_pixel_pace: assert property (pix_ready |=> !pix_ready [*8])
      else $error("pixels taken faster than the pixel clock");
endmodule // lcd_fmt_monitor

bind lcd_pixel_output_formatter lcd_fmt_monitor lcd_fmt_monitor_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .pix_ready(pix_ready), .pal_dma_req(pal_dma_req), .pal_dma_chan(pal_dma_chan),
   .pal_dma_word(pal_dma_word), .pal_dma_valid(pal_dma_valid), .pins(pins));

// *** tb/panel_model.sv ***
// Panel stand-in that counts the lines it receives.
`timescale 1ns/100ps
module panel_model (
   // Sampling clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Panel pins and received line count.
   input wire lcd_fmt_pkg::panel_pins_t pins,
   output int lines
);
   import lcd_fmt_pkg::*;
   logic hs_q;
   // A line is latched on each leading edge of the line sync.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hs_q <= 1'b0;
         lines <= 0;
      end
      else
      begin
         hs_q <= pins.hsync;
         if (pins.hsync && !hs_q)
            lines <= lines + 1;
      end
   end
endmodule // panel_model

// *** tb/tb.sv ***
// Self-checking bench of the pixel output formatter.
`timescale 1ns/100ps
`include "lcd_fmt_consts.svh"
module tb;
   import lcd_fmt_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, link_clk, pix_valid, pal_dma_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, pix_data, pal_dma_data, q;
   logic pready, pslverr, pix_ready, pal_dma_req, e;
   logic [1:0] pal_dma_chan;
   logic [6:0] pal_dma_word;
   panel_pins_t pins;
   int bad_count, total_checks, lines;
   lcd_pixel_output_formatter lcd_pixel_output_formatter_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_clk(link_clk), .pix_valid(pix_valid), .pix_data(pix_data),
      .pix_ready(pix_ready), .pal_dma_req(pal_dma_req), .pal_dma_chan(pal_dma_chan),
      .pal_dma_word(pal_dma_word), .pal_dma_valid(pal_dma_valid),
      .pal_dma_data(pal_dma_data), .pins(pins));
   panel_model panel_model_inst (.pclk(pclk), .presetn(presetn), .pins(pins), .lines(lines));
   // System clock, and a pixel clock of unrelated phase.
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial
   begin
      link_clk = 1'b0;
      #13.3;
      forever #40 link_clk = ~link_clk;
   end
   task report_and_stop;
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus transfer; read data and error flag land in q and e.
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
         bad_count++;
         report_and_stop();
      end
   endtask
   task reset_dut;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // Reset values and the unmapped place.
   task automatic t_regs;
      bus(0, `OFF_CTRL, 0);
      chk(q, `CTRL_RST);
      bus(0, `OFF_TIMING, 0);
      chk(q, `TIMING_RST);
      for (int i = 0; i < 4; i++)
      begin
         bus(0, `OFF_POS_BASE + 12'(4 * i), 0);
         chk(q, `POS_RST);
      end
      bus(1, 12'h040, 32'hFFFF_FFFF);
      chk({31'h0, e}, 1);
      bus(0, 12'h040, 0);
      chk({e, q[30:0]}, 32'h8000_0000);
   endtask
   // Palette load with the source answering every cycle.
   task automatic t_palette(input logic [2:0] bpp, input int words);
      int n;
      n = 0;
      pal_dma_valid <= 1'b1;
      bus(1, `OFF_CTRL, {23'h0, bpp, 6'h00});
      bus(1, `OFF_PALCTL, 32'h0000_0001);
      // Entry e holds e from bit 10 up, so bit 10 marks the odd entries.
      pal_dma_data <= 32'h0400_0000;
      @(posedge pclk);
      while (pal_dma_req === 1'b1 && n < 200)
      begin
         chk({25'h0, pal_dma_word}, n);
         n++;
         pal_dma_data <= {16'((2 * n + 1) << 10), 16'((2 * n) << 10)};
         @(posedge pclk);
      end
      chk(n, words);
   endtask
   task automatic t_bypass;
      int n;
      n = 0;
      bus(1, `OFF_CTRL, 32'h0000_0100);
      bus(1, `OFF_PALCTL, 32'h0000_0001);
      repeat (8)
      begin
         @(posedge pclk);
         #1;
         n += (pal_dma_req === 1'b1);
      end
      chk(n, 0);
   endtask
   // Passive panel: 16-pixel lines, a steady pixel, then the pins after 24 pixels.
   task automatic t_stn(input logic [31:0] ctrl, input logic [31:0] px, input logic [17:0] x);
      int n;
      int k;
      n = 0;
      k = 0;
      reset_dut();
      pix_data <= px;
      pix_valid <= 1'b1;
      bus(1, `OFF_TIMING, 32'h0007_0010);
      bus(1, `OFF_CTRL, ctrl);
      bus(0, `OFF_STATUS, 0);
      chk({31'h0, q[0]}, 1);
      while (n < 24 && k < 4000)
      begin
         @(posedge pclk);
         #1;
         k++;
         n += (pix_ready === 1'b1);
      end
      repeat (2) @(posedge pclk);
      #1;
      chk(n, 24);
      chk({14'h0, pins.data}, {14'h0, x});
   endtask
   // Longest high run tells a pulse from a toggle.
   task automatic t_special(input logic [1:0] m, input logic [3:0] tog);
      int run[4] = '{default: 0};
      int mx[4] = '{default: 0};
      logic [3:0] s;
      reset_dut();
      bus(1, `OFF_SPECIAL, {30'h0, m});
      bus(1, `OFF_CTRL, 32'h0000_0105);
      repeat (1500)
      begin
         @(posedge pclk);
         #1;
         s = {pins.power_save_signal, pins.start_pulse, pins.reverse, pins.line_clear};
         for (int i = 0; i < 4; i++)
         begin
            run[i] = s[i] === 1'b1 ? run[i] + 1 : 0;
            mx[i] = run[i] > mx[i] ? run[i] : mx[i];
         end
      end
      for (int i = 0; i < 4; i++)
      begin
         chk({31'h0, mx[i] > 0}, 1);
         chk({31'h0, mx[i] > 64}, {31'h0, tog[i]});
      end
      chk({31'h0, lines > 0}, 1);
   endtask
   // Main sequence.
   initial
   begin
      bad_count = 0;
      total_checks = 0;
      {presetn, psel, penable, pwrite, pix_valid, pal_dma_valid} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pix_data = 32'h0000_0000;
      pal_dma_data = 32'h0000_0000;
      reset_dut();
      t_regs();
      t_palette(3'h0, 1);
      t_palette(3'h1, 2);
      t_palette(3'h2, 8);
      t_palette(3'h3, 128);
      t_bypass();
      t_stn(32'h0000_0101, 32'h0000_07E0, 18'h0_0001);
      t_stn(32'h0000_0111, 32'h0000_07E0, 18'h0_0003);
      t_stn(32'h0000_0121, 32'h0000_07E0, 18'h0_000F);
      t_stn(32'h0000_0131, 32'h0000_07E0, 18'h0_00FF);
      t_stn(32'h0000_0331, 32'h0000_0200, 18'h0_00FF);
      t_stn(32'h0000_0131, 32'h0000_0200, 18'h0_0000);
      t_stn(32'h0000_0331, 32'h0000_8400, 18'h0_0000);
      t_stn(32'h0000_00F1, 32'h0000_0001, 18'h0_00FF);
      t_stn(32'h0000_2131, 32'h0000_07E0, 18'h0_FF00);
      t_stn(32'h0000_2131, 32'h07E0_0000, 18'h0_00FF);
      t_stn(32'h0000_2121, 32'h0000_07E0, 18'h0_0F00);
      t_special(2'h1, 4'b0010);
      t_special(2'h2, 4'b1010);
      t_special(2'h3, 4'b1110);
      report_and_stop();
   end
endmodule // tb
